// [logic/card_column_buffer_port.sv]
// Card reader command bits, column buffer and its two bus views
// What this block does
// - Interrupt request when allowed and any flag except overrun set
// - Twelve-bit buffer loaded one column per load
// - Buffered column returned on buffer read
// - Raw view: twelve low lines, top four zero
// - Raw view row order 12,11,10,1..9
// - Buffer views read-only, writes leave the buffered column unchanged
// - Packed view: zones 12..8 plus ORed octal
// - Addressing a view clears column-available flag
// - Skip bit blocks overrun flag
// - Overrun on unread column; inhibits column-available
`timescale 1ns/100ps
module card_column_buffer_port #(
  parameter int COL_W = card_reader_pkg::COL_W,
  parameter int FIFO_DEPTH = card_reader_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic busInit,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [1:0] regIndex,
  input wire logic [card_reader_pkg::DATA_W-1:0] regWdata,
  output logic [card_reader_pkg::DATA_W-1:0] regRdata,
  output logic irqRequest,
  output logic readCardPulse,
  output logic skipActive,
  input wire logic colValid,
  input wire logic [COL_W-1:0] colData,
  output logic colReady,
  input wire logic errorFlag,
  input wire logic cardDoneFlag,
  input wire logic wentOnlineFlag
);
  localparam int DW = card_reader_pkg::DATA_W;

  logic rstMeta_q, rstSync_q;
  logic [COL_W-1:0] column_q, column_d;
  logic colAvail_q, colAvail_d;
  logic overrun_q, overrun_d;
  logic irqAllow_q, irqAllow_d;
  logic skip_q, skip_d;
  logic readPulse_q, readPulse_d;
  logic irq_q, irq_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic load, viewAccess, statusWrite;

  column_stream_if #(.WIDTH(COL_W)) drain ();

  // Raw view: rows already in raw order, upper lines zero
  function automatic logic [DW-1:0] rawView(input logic [COL_W-1:0] c);
    rawView = {4'h0, c};
  endfunction : rawView

  // Packed view: zones 12..8 and ORed octal code of rows 1..7
  function automatic logic [DW-1:0] packedView(
      input logic [COL_W-1:0] c);
    logic [2:0] oct;
    oct = 3'h0;
    for (int k = 1; k <= 7; k++) begin
      if (c[card_reader_pkg::RAW_ROW1 + 1 - k]) begin
        oct = oct | 3'(k);
      end
    end
    packedView = {8'h00,
                  c[card_reader_pkg::RAW_ROW12],
                  c[card_reader_pkg::RAW_ROW11],
                  c[card_reader_pkg::RAW_ROW10],
                  c[card_reader_pkg::RAW_ROW9],
                  c[card_reader_pkg::RAW_ROW8],
                  oct};
  endfunction : packedView

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  column_fifo #(.WIDTH(COL_W), .DEPTH(FIFO_DEPTH)) fifo (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_q),
    .inValid(colValid),
    .inData(colData),
    .inReady(colReady),
    .outPort(drain.source)
  );

  // No transfers while overrun stands
  assign drain.ready = !overrun_q;

  // Next values of buffer, flags, control bits and read data
  always_comb begin
    load = drain.valid && drain.ready;
    viewAccess = (regRead || regWrite) &&
                 ((regIndex == card_reader_pkg::IDX_RAW) ||
                  (regIndex == card_reader_pkg::IDX_PACKED));
    statusWrite = regWrite && (regIndex == card_reader_pkg::IDX_STATUS);
    column_d = column_q;
    colAvail_d = colAvail_q;
    overrun_d = overrun_q;
    irqAllow_d = irqAllow_q;
    skip_d = skip_q;
    readPulse_d = 1'b0;
    rdata_d = rdata_q;
    // Column access clears flag; buffer content untouched
    if (viewAccess) begin
      colAvail_d = 1'b0;
    end
    // Writing status clears overrun and loads control bits
    if (statusWrite) begin
      overrun_d = 1'b0;
      irqAllow_d = regWdata[card_reader_pkg::BIT_IRQALLOW];
      skip_d = regWdata[card_reader_pkg::BIT_SKIP];
      readPulse_d = regWdata[card_reader_pkg::BIT_READCMD];
    end
    // Column load; set beats the clear in the same cycle
    if (load) begin
      column_d = drain.data;
      if (colAvail_q && !viewAccess && !skip_q) begin
        overrun_d = 1'b1;
        colAvail_d = 1'b0;
      end else if (!skip_q) begin
        colAvail_d = 1'b1;
      end
    end
    // Bus read data
    if (regRead) begin
      unique case (regIndex)
        card_reader_pkg::IDX_STATUS: begin
          rdata_d = card_reader_pkg::RST_WORD;
          rdata_d[card_reader_pkg::BIT_ERROR] = errorFlag;
          rdata_d[card_reader_pkg::BIT_DONE] = cardDoneFlag;
          rdata_d[card_reader_pkg::BIT_OVERRUN] = overrun_q;
          rdata_d[card_reader_pkg::BIT_ONLINE] = wentOnlineFlag;
          rdata_d[card_reader_pkg::BIT_COLAVAIL] = colAvail_q;
          rdata_d[card_reader_pkg::BIT_IRQALLOW] = irqAllow_q;
          rdata_d[card_reader_pkg::BIT_SKIP] = skip_q;
        end
        card_reader_pkg::IDX_RAW: rdata_d = rawView(column_q);
        card_reader_pkg::IDX_PACKED: rdata_d = packedView(column_q);
        default: rdata_d = card_reader_pkg::RST_WORD;
      endcase
    end
    // Bus initialize clears command and flag state
    if (busInit) begin
      colAvail_d = 1'b0;
      overrun_d = 1'b0;
      irqAllow_d = 1'b0;
      skip_d = 1'b0;
      readPulse_d = 1'b0;
    end
    irq_d = irqAllow_d && (errorFlag || cardDoneFlag ||
                           wentOnlineFlag || colAvail_d);
  end

  // State registers
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      column_q <= card_reader_pkg::RST_COL;
      colAvail_q <= card_reader_pkg::RST_FLAG;
      overrun_q <= card_reader_pkg::RST_FLAG;
      irqAllow_q <= card_reader_pkg::RST_FLAG;
      skip_q <= card_reader_pkg::RST_FLAG;
      readPulse_q <= card_reader_pkg::RST_FLAG;
      irq_q <= card_reader_pkg::RST_FLAG;
      rdata_q <= card_reader_pkg::RST_WORD;
    end else begin
      column_q <= column_d;
      colAvail_q <= colAvail_d;
      overrun_q <= overrun_d;
      irqAllow_q <= irqAllow_d;
      skip_q <= skip_d;
      readPulse_q <= readPulse_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
  assign irqRequest = irq_q;
  assign readCardPulse = readPulse_q;
  assign skipActive = skip_q;
endmodule : card_column_buffer_port

// [logic/card_reader_pkg.sv]
// Shared constants for the card column buffer port
package card_reader_pkg;
  localparam int DATA_W = 16;
  localparam int COL_W = 12;
  localparam int FIFO_DEPTH = 32;
  // Register selector codes on the register port
  localparam logic [1:0] IDX_STATUS = 2'h0;
  localparam logic [1:0] IDX_RAW = 2'h1;
  localparam logic [1:0] IDX_PACKED = 2'h2;
  // Status register bit positions
  localparam int BIT_ERROR = 15;
  localparam int BIT_DONE = 14;
  localparam int BIT_OVERRUN = 11;
  localparam int BIT_ONLINE = 10;
  localparam int BIT_COLAVAIL = 7;
  localparam int BIT_IRQALLOW = 6;
  localparam int BIT_SKIP = 1;
  localparam int BIT_READCMD = 0;
  // Raw view bit positions of zone rows and of row 1
  localparam int RAW_ROW12 = 11;
  localparam int RAW_ROW11 = 10;
  localparam int RAW_ROW10 = 9;
  localparam int RAW_ROW1 = 8;
  localparam int RAW_ROW8 = 1;
  localparam int RAW_ROW9 = 0;
  // Values after reset
  localparam logic RST_FLAG = 1'b0;
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [COL_W-1:0] RST_COL = 12'h000;
endpackage : card_reader_pkg

// [logic/column_stream_if.sv]
// Valid/ready column stream between FIFO and buffer logic
`timescale 1ns/100ps
interface column_stream_if #(parameter int WIDTH = 12);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : column_stream_if

// [logic/column_fifo.sv]
// Column FIFO with registered show-ahead read data
`timescale 1ns/100ps
module column_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rstSync_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  column_stream_if.source outPort
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic full_q, full_d;
  logic [WIDTH-1:0] head_q, head_d;
  logic push, pop;

  // Pointer, count and head-word next values
  always_comb begin
    push = inValid && !full_q;
    pop = outPort.valid && outPort.ready;
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    full_d = (count_d == (AW+1)'(DEPTH));
    // Bypass when the word being written becomes the head
    if (push && (wrPtr_q == rdPtr_d)) begin
      head_d = inData;
    end else begin
      head_d = mem[rdPtr_d];
    end
  end

  // State registers
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      full_q <= 1'b0;
      head_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      full_q <= full_d;
      head_q <= head_d;
    end
  end

  // Storage array
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  assign inReady = !full_q;
  assign outPort.valid = (count_q != '0);
  assign outPort.data = head_q;
endmodule : column_fifo

// [tb/card_feeder.sv]
// Card reader model offering columns on a valid/ready stream
`timescale 1ns/100ps
module card_feeder (
  input wire logic clk_sys,
  input wire logic colReady,
  output logic colValid,
  output logic [11:0] colData
);
  initial colValid = 1'b0;
  initial colData = 12'h000;
  // One column per call, held until taken or for at most 8 cycles; stale data inverted
  task automatic feed(input logic [11:0] c, output logic ok);
    @(posedge clk_sys);
    colValid <= 1'b1;
    colData <= c;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk_sys);
      ok = colReady;
      @(posedge clk_sys);
    end
    colValid <= 1'b0;
    colData <= ~c;
  endtask : feed
endmodule : card_feeder

// [tb/card_column_buffer_port_chk.sv]
// Port assertions for the card column buffer port
`timescale 1ns/100ps
module card_column_buffer_port_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic busInit,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [1:0] regIndex,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic readCardPulse,
  input wire logic skipActive
);
  logic stW;
  // Status register write strobe
  assign stW = regWrite && regIndex == card_reader_pkg::IDX_STATUS;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_cmd_pulse: assert property (
    stW && regWdata[0] && !busInit |=> readCardPulse) else $error("no pulse");
  chk_pulse_cause: assert property (
    readCardPulse |-> $past(stW && regWdata[0])) else $error("stray pulse");
  chk_skip_bit: assert property (
    stW && !busInit |=> skipActive == $past(regWdata[1]))
    else $error("skip bit");
  chk_init_clear: assert property (
    busInit |=> !skipActive && !readCardPulse) else $error("init");
  chk_status_zero: assert property (
    regRead && regIndex == 2'h0 |=> !regRdata[0]) else $error("bit 0");
  chk_raw_upper: assert property (
    regRead && regIndex == 2'h1 |=> regRdata[15:12] == 4'h0)
    else $error("raw top");
  chk_packed_upper: assert property (
    regRead && regIndex == 2'h2 |=> regRdata[15:8] == 8'h00)
    else $error("packed top");
  chk_rdata_hold: assert property (
    !regRead && !busInit |=> $stable(regRdata)) else $error("rdata moved");
endmodule : card_column_buffer_port_chk
bind card_column_buffer_port card_column_buffer_port_chk
  u_card_column_buffer_port_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .busInit(busInit), .regRead(regRead), .regWrite(regWrite),
  .regIndex(regIndex), .regWdata(regWdata), .regRdata(regRdata),
  .readCardPulse(readCardPulse), .skipActive(skipActive));

// [tb/test_card_column_buffer_port.sv]
// Directed test of the card column buffer port
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module test_card_column_buffer_port;
  logic clk_sys = 1'b0, arst_n = 1'b0, busInit = 1'b0;
  logic regRead = 1'b0, regWrite = 1'b0, colValid, colReady, ok;
  logic [2:0] flg = 3'h0;
  logic [1:0] regIndex = 2'h0;
  logic [15:0] regWdata = 16'h0000, regRdata, d;
  logic [11:0] colData;
  logic irqRequest, readCardPulse, skipActive;
  int checked = 0, n_mismatch = 0;
  // Clock of 100 ns
  always #50 clk_sys = ~clk_sys;
  card_column_buffer_port u_card_column_buffer_port (.clk_sys(clk_sys),
    .arst_n(arst_n), .busInit(busInit), .regRead(regRead),
    .regWrite(regWrite), .regIndex(regIndex), .regWdata(regWdata),
    .regRdata(regRdata), .irqRequest(irqRequest),
    .readCardPulse(readCardPulse), .skipActive(skipActive),
    .colValid(colValid), .colData(colData), .colReady(colReady),
    .errorFlag(flg[2]), .cardDoneFlag(flg[1]), .wentOnlineFlag(flg[0]));
  card_feeder u_card_feeder (.clk_sys(clk_sys), .colReady(colReady),
    .colValid(colValid), .colData(colData));
  task automatic regWr(input logic [1:0] i, input logic [15:0] w);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regIndex <= i;
    regWdata <= w;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(negedge clk_sys);
  endtask : regWr
  task automatic regRd(input logic [1:0] i, output logic [15:0] r);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regIndex <= i;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    r = regRdata;
  endtask : regRd
  // Packed view: zones 12..8 then ORed octal row codes
  function automatic logic [15:0] packx(input logic [11:0] c);
    logic [2:0] o;
    o = 3'h0;
    for (int k = 1; k <= 7; k++) if (c[9 - k]) o = o | 3'(k);
    return {8'h00, c[11], c[10], c[9], c[0], c[1], o};
  endfunction : packx
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    #5000000;
    n_mismatch++;
    summarize();
  end
  // Test sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    regRd(2'h0, d); `CHK(d, 16'h0000)
    regWr(2'h0, 16'h0043); `CHK(skipActive, 1'b1)
    regRd(2'h0, d); `CHK(d, 16'h0042)
    $display("command bits done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys) flg <= 3'h1 << i;
      repeat (3) @(negedge clk_sys);
      `CHK(irqRequest, 1'b1)
    end
    @(posedge clk_sys) flg <= 3'h7;
    regWr(2'h0, 16'h0002);
    repeat (2) @(negedge clk_sys);
    `CHK(irqRequest, 1'b0)
    @(posedge clk_sys) flg <= 3'h0;
    $display("interrupt done");
    u_card_feeder.feed(12'h001, ok);
    u_card_feeder.feed(12'h002, ok);
    repeat (4) @(negedge clk_sys);
    regRd(2'h0, d); `CHK(d, 16'h0002)
    regWr(2'h0, 16'h0000);
    $display("skip done");
    u_card_feeder.feed(12'hA5C, ok); `CHK(ok, 1'b1)
    repeat (4) @(negedge clk_sys);
    regRd(2'h0, d); `CHK(d[7], 1'b1)
    regRd(2'h1, d); `CHK(d, 16'h0A5C)
    regRd(2'h0, d); `CHK(d[7], 1'b0)
    regRd(2'h2, d); `CHK(d, packx(12'hA5C))
    regWr(2'h1, 16'hFFFF);
    regRd(2'h1, d); `CHK(d, 16'h0A5C)
    regRd(2'h3, d); `CHK(d, 16'h0000)
    $display("views done");
    u_card_feeder.feed(12'h111, ok);
    u_card_feeder.feed(12'h222, ok);
    repeat (4) @(negedge clk_sys);
    regRd(2'h0, d); `CHK(d[11], 1'b1)
    `CHK(d[7], 1'b0)
    $display("overrun done");
    for (int n = 0; n < 40 && ok; n++) u_card_feeder.feed(12'h0F0, ok);
    `CHK(ok, 1'b0)
    repeat (40) begin
      regWr(2'h0, 16'h0000);
      regRd(2'h1, d);
    end
    `CHK(colReady, 1'b1)
    @(posedge clk_sys) busInit <= 1'b1;
    @(posedge clk_sys) busInit <= 1'b0;
    regRd(2'h0, d); `CHK(d, 16'h0000)
    $display("buffer done");
    summarize();
  end
endmodule : test_card_column_buffer_port
